// ==== hw/t1_status_map.vh ====
// Purpose: register offsets, step decodes and fixed values of the framer status block
// Assumes: byte-wide read bus, one address per register
// Notes:   read-only registers; clear and simulate commands arrive as pulses
`ifndef T1_STATUS_MAP_VH
`define T1_STATUS_MAP_VH

// register offsets
`define OFS_ALARM_SIM    8'h04
`define OFS_SIG_STACK    8'h07
`define OFS_FSDL         8'h80
`define OFS_MF_STATUS    8'h05
`define OFS_FRAMING      8'h06
`define OFS_CNT_EXT      8'h08

// fixed bits of sparse registers
`define ALARM_SIM_FIXED  1'b1
`define FSDL_PAD         2'b11

// step decodes, bit n set means step n
`define STEPS_SLIP_POS   8'h02
`define STEPS_SLIP_NEG   8'h20
`define STEPS_LOS_FEC    8'h44
`define STEPS_NOS_CLK    8'h40
`define STEPS_AUTO_CLR   8'h99
`define STEPS_RX_PAR     8'h60
`define STEPS_TX_PAR     8'h06
`define STEPS_GLOBAL_PAR 8'h66
`define STEPS_TX_SLIP    8'h66

// signaling modes, channels and stack depth
`define SIG_MODE_CC      1'b0
`define SIG_MODE_BR      1'b1
`define SIG_CHAN_A       5'h11
`define SIG_CHAN_B       5'h18
`define SIG_CC_BITS      5'h18
`define STACK_DEPTH      2'h3

// multiframe loss threshold
`define MULTIFRAME_LOSS_FLAG_BAD_LIMIT   3'h2

`endif

// ==== hw/sig_stack_mem.v ====
// Purpose: three-byte receive signaling stack storage
// Assumes: one write and one read port on sys_clk
// Notes:   read data registered, so it trails the address by one edge
`timescale 1ns/1ps
module sig_stack_mem (
	input  wire       sys_clk,
	input  wire       sys_rst,
	input  wire       wrEn,
	input  wire [1:0] wrAddr,
	input  wire [7:0] wrData,
	input  wire [1:0] rdAddr,
	output reg  [7:0] rdData_reg
);
	reg [7:0] mem [0:3];

	// ------------------------------------------------------------
	// storage and registered read
	// ------------------------------------------------------------
	// no reset on the array: contents are only read after a full load
	always @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_reg <= 8'h00;
		end else begin
			rdData_reg <= mem[rdAddr];
		end
	end
endmodule

// ==== hw/t1_framer_status_and_alarm_sim.v ====
// Purpose: status flags, alarm simulation steps and receive signaling stack of a T1 framer
// Assumes: all inputs synchronous to sys_clk; event inputs are one-cycle pulses
// Notes:   read strobes are sampled, so a read needs rd_n low across at least one rising clock edge
`timescale 1ns/1ps
`include "t1_status_map.vh"
module t1_framer_status_and_alarm_sim (
	input  wire       sys_clk,
	input  wire       sys_rst,
	input  wire       chip_select_n,
	input  wire       rd_n,
	input  wire       dma_ack_n,
	input  wire [7:0] addr,
	input  wire       simulate_cmd,
	input  wire       clear_cmd,
	input  wire [4:0] channel_select_reg,
	input  wire       rxParityEv,
	input  wire [4:0] rxParityChan,
	input  wire       txParityEv,
	input  wire [4:0] txParityChan,
	input  wire       txSlipEv,
	input  wire       rxSlipEv,
	input  wire       fbitErrEv,
	input  wire       losIn,
	input  wire       mfGoodEv,
	input  wire       rxMfStartEv,
	input  wire       rxFrame37,
	input  wire       rx_mf_ack,
	input  wire       tx_mf_begin_out,
	input  wire       txDChanStart,
	input  wire       mfFormat,
	input  wire       mlosWindow5,
	input  wire       mfPatEv,
	input  wire       mfPatBad,
	input  wire       mfResyncEv,
	input  wire       opticalEnable,
	input  wire       rx_rail_pos_in,
	input  wire       rx_rail_neg_in,
	input  wire       fbitPosErrEv,
	input  wire [2:0] fbitPosIdx,
	input  wire       historyUpdateEv,
	input  wire [5:0] dlSubstMask,
	input  wire       internal_sig_enable,
	input  wire       sigMode,
	input  wire       sig_channel_24_select,
	input  wire       sigBitEv,
	input  wire       sigBit,
	input  wire [4:0] sigChan,
	input  wire       sigFrameEndEv,
	input  wire       fsdlBitEv,
	input  wire       fsdlBit,
	input  wire [2:0] fsdlIdx,
	input  wire [3:0] cntExtIn,
	output reg  [7:0] rdData_reg,
	output reg        rdDataOe_reg,
	output reg        rx_dma_request_reg,
	output reg        rx_mf_begin_out_reg,
	output reg        simForceSlipPos_reg,
	output reg        simForceSlipNeg_reg,
	output reg        simForceLos_reg,
	output reg        simForceFec_reg,
	output reg        simForceNosClk_reg,
	output reg        simAutoClear_reg
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// step membership test against an eight-bit step mask
	function stepIn;
		input [7:0] mask;
		input [2:0] step;
		begin
			stepIn = mask[step];
		end
	endfunction

	// count of ones in a five-bit pattern history
	function [2:0] onesOf;
		input [4:0] v;
		begin
			onesOf = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
				+ {2'b00, v[3]} + {2'b00, v[4]};
		end
	endfunction

	// ------------------------------------------------------------
	// alarm simulation step counter
	// ------------------------------------------------------------
	reg  [2:0] simStep_reg;
	wire [2:0] simStep_next = simulate_cmd ? simStep_reg + 3'h1 : simStep_reg;
	wire       simEnter     = simulate_cmd;
	wire       simSetRxPar  = simEnter & stepIn(`STEPS_RX_PAR, simStep_next);
	wire       simSetTxPar  = simEnter & stepIn(`STEPS_TX_PAR, simStep_next);
	wire       simSetGPar   = simEnter & stepIn(`STEPS_GLOBAL_PAR, simStep_next);
	wire       simSetTxSlip = simEnter & stepIn(`STEPS_TX_SLIP, simStep_next);

	// wraps from 7 to 0, so eight commands complete one pass
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			simStep_reg <= 3'h0;
		end else begin
			simStep_reg <= simStep_next;
		end
	end

	// forcing outputs decoded from the next step so they track it without lag
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			simForceSlipPos_reg <= 1'b0;
			simForceSlipNeg_reg <= 1'b0;
			simForceLos_reg     <= 1'b0;
			simForceFec_reg     <= 1'b0;
			simForceNosClk_reg  <= 1'b0;
			simAutoClear_reg    <= 1'b1;
		end else begin
			simForceSlipPos_reg <= stepIn(`STEPS_SLIP_POS, simStep_next);
			simForceSlipNeg_reg <= stepIn(`STEPS_SLIP_NEG, simStep_next);
			simForceLos_reg     <= stepIn(`STEPS_LOS_FEC, simStep_next);
			simForceFec_reg     <= stepIn(`STEPS_LOS_FEC, simStep_next);
			simForceNosClk_reg  <= stepIn(`STEPS_NOS_CLK, simStep_next);
			simAutoClear_reg    <= stepIn(`STEPS_AUTO_CLR, simStep_next);
		end
	end

	// ------------------------------------------------------------
	// additional status flags
	// ------------------------------------------------------------
	reg freezeSig_reg;
	reg rxParErr_reg;
	reg txParErr_reg;
	reg txSlip_reg;
	reg globalPar_reg;
	reg dmaSlip_reg;
	// entering a quiet step drops the parity and transmit slip flags that simulation raised earlier
	wire autoClr = simEnter & stepIn(`STEPS_AUTO_CLR, simStep_next);
	wire rxParSel = rxParityEv & (rxParityChan == channel_select_reg);
	wire txParSel = txParityEv & (txParityChan == channel_select_reg);
	wire slipSeen = rxSlipEv | simForceSlipPos_reg | simForceSlipNeg_reg;
	wire stackSlip;

	// in every flag below a set in the clear cycle wins over the clear
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			freezeSig_reg <= 1'b0;
			rxParErr_reg  <= 1'b0;
			txParErr_reg  <= 1'b0;
			txSlip_reg    <= 1'b0;
			globalPar_reg <= 1'b0;
			dmaSlip_reg   <= 1'b0;
		end else begin
			if (fbitErrEv | losIn | slipSeen) begin
				freezeSig_reg <= 1'b1;
			end else if (mfGoodEv) begin
				freezeSig_reg <= 1'b0;
			end
			if (rxParSel | simSetRxPar) begin
				rxParErr_reg <= 1'b1;
			end else if (clear_cmd | autoClr) begin
				rxParErr_reg <= 1'b0;
			end
			if (txParSel | simSetTxPar) begin
				txParErr_reg <= 1'b1;
			end else if (clear_cmd | autoClr) begin
				txParErr_reg <= 1'b0;
			end
			if (txSlipEv | simSetTxSlip) begin
				txSlip_reg <= 1'b1;
			end else if (clear_cmd | autoClr) begin
				txSlip_reg <= 1'b0;
			end
			if (rxParityEv | txParityEv | simSetGPar) begin
				globalPar_reg <= 1'b1;
			end else if (clear_cmd | autoClr) begin
				globalPar_reg <= 1'b0;
			end
			if (stackSlip) begin
				dmaSlip_reg <= 1'b1;
			end else if (clear_cmd) begin
				dmaSlip_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// multiframe begin pins and flags
	// ------------------------------------------------------------
	reg rxRemoteSw_reg;
	reg rxMfBegin_reg;
	reg txRemoteSw_reg;
	reg txMfBegin_reg;
	reg txMfOutPrev_reg;
	wire txRise = tx_mf_begin_out & ~txMfOutPrev_reg;

	// receive begin pin stays up until software acknowledges the fs/dl read
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_mf_begin_out_reg <= 1'b0;
			rxRemoteSw_reg      <= 1'b0;
			rxMfBegin_reg       <= 1'b0;
		end else begin
			if (rxMfStartEv) begin
				rx_mf_begin_out_reg <= 1'b1;
				rxRemoteSw_reg      <= mfFormat & rxFrame37;
				rxMfBegin_reg       <= ~rxFrame37;
			end else if (rx_mf_ack) begin
				rx_mf_begin_out_reg <= 1'b0;
				rxRemoteSw_reg      <= 1'b0;
				rxMfBegin_reg       <= 1'b0;
			end
		end
	end

	// transmit flags latch the cause on the rising edge and drop with the pin
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txMfOutPrev_reg <= 1'b0;
			txRemoteSw_reg  <= 1'b0;
			txMfBegin_reg   <= 1'b0;
		end else begin
			txMfOutPrev_reg <= tx_mf_begin_out;
			if (~tx_mf_begin_out) begin
				txRemoteSw_reg <= 1'b0;
				txMfBegin_reg  <= 1'b0;
			end else if (txRise) begin
				txRemoteSw_reg <= mfFormat & txDChanStart;
				txMfBegin_reg  <= ~txDChanStart;
			end
		end
	end

	// ------------------------------------------------------------
	// framing status: multiframe loss, line error, error history
	// ------------------------------------------------------------
	reg  [4:0] patHist_reg;
	reg        mfLoss_reg;
	reg        lineErr_reg;
	reg  [5:0] fehAcc_reg;
	reg  [5:0] feh_reg;
	wire [4:0] patHist_next = {patHist_reg[3:0], mfPatBad};
	wire [4:0] patWin       = mlosWindow5 ? patHist_next : {1'b0, patHist_next[3:0]};
	wire [5:0] fehHit       = (fbitPosErrEv && fbitPosIdx < 3'h6) ?
		(6'h01 << fbitPosIdx) : 6'h00;

	// pattern history only moves on a pattern check; resync starts it afresh
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			patHist_reg <= 5'h00;
			mfLoss_reg  <= 1'b0;
		end else begin
			if (mfResyncEv) begin
				patHist_reg <= 5'h00;
				mfLoss_reg  <= 1'b0;
			end else if (mfPatEv) begin
				patHist_reg <= patHist_next;
				if (onesOf(patWin) >= `MULTIFRAME_LOSS_FLAG_BAD_LIMIT) begin
					mfLoss_reg <= 1'b1;
				end
			end
		end
	end

	// history collects between updates; an error in the update cycle lands in it
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lineErr_reg <= 1'b0;
			fehAcc_reg  <= 6'h00;
			feh_reg     <= 6'h00;
		end else begin
			lineErr_reg <= ~opticalEnable & rx_rail_pos_in & rx_rail_neg_in;
			if (historyUpdateEv) begin
				feh_reg    <= (fehAcc_reg | fehHit) & ~dlSubstMask;
				fehAcc_reg <= 6'h00;
			end else begin
				fehAcc_reg <= fehAcc_reg | fehHit;
			end
		end
	end

	// ------------------------------------------------------------
	// receive signaling assembly and stack
	// ------------------------------------------------------------
	reg  [23:0] sigAsm_reg;
	reg  [4:0]  sigCnt_reg;
	reg  [23:0] sigLoad_reg;
	reg  [1:0]  loadIdx_reg;
	reg         loading_reg;
	reg  [1:0]  stackPtr_reg;
	wire [4:0]  ccChan   = sig_channel_24_select ? `SIG_CHAN_B : `SIG_CHAN_A;
	wire [4:0]  brIdx    = sigChan - 5'h01;
	wire        ccBit    = sigBitEv & (sigChan == ccChan) & (sigMode == `SIG_MODE_CC);
	wire        ccFull   = ccBit & (sigCnt_reg == `SIG_CC_BITS - 5'h01);
	wire        brFull   = sigFrameEndEv & (sigMode == `SIG_MODE_BR);
	wire        stackReq = internal_sig_enable & (ccFull | brFull);
	wire [7:0]  stackByte;
	wire [7:0]  loadByte = (loadIdx_reg == 2'h0) ? sigLoad_reg[23:16] :
		(loadIdx_reg == 2'h1) ? sigLoad_reg[15:8] : sigLoad_reg[7:0];
	assign stackSlip = stackReq & rx_dma_request_reg;

	// cc mode shifts so the earliest bit ends in the first byte's msb
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sigAsm_reg <= 24'h000000;
			sigCnt_reg <= 5'h00;
		end else begin
			if (ccBit) begin
				sigAsm_reg <= {sigAsm_reg[22:0], sigBit};
				sigCnt_reg <= ccFull ? 5'h00 : sigCnt_reg + 5'h01;
			end else if (sigBitEv && sigMode == `SIG_MODE_BR && brIdx < 5'h18) begin
				sigAsm_reg[5'd23 - brIdx] <= sigBit;
			end
		end
	end

	// a new request reloads over unread bytes; the slip flag records the loss
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sigLoad_reg <= 24'h000000;
			loadIdx_reg <= 2'h0;
			loading_reg <= 1'b0;
		end else begin
			if (stackReq) begin
				sigLoad_reg <= ccBit ? {sigAsm_reg[22:0], sigBit} : sigAsm_reg;
				loadIdx_reg <= 2'h0;
				loading_reg <= 1'b1;
			end else if (loading_reg) begin
				loadIdx_reg <= loadIdx_reg + 2'h1;
				loading_reg <= (loadIdx_reg != `STACK_DEPTH - 2'h1);
			end
		end
	end

	sig_stack_mem stackMem (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.wrEn       (loading_reg),
		.wrAddr     (loadIdx_reg),
		.wrData     (loadByte),
		.rdAddr     (stackPtr_reg),
		.rdData_reg (stackByte)
	);

	// ------------------------------------------------------------
	// fs/dl capture
	// ------------------------------------------------------------
	reg [5:0] fsdlAsm_reg;
	reg [5:0] fsdl_reg;

	// bits arrive already mapped; the set is frozen when the receive begin pin rises
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fsdlAsm_reg <= 6'h00;
			fsdl_reg    <= 6'h00;
		end else begin
			if (fsdlBitEv && fsdlIdx < 3'h6) begin
				fsdlAsm_reg[fsdlIdx] <= fsdlBit;
			end
			if (rxMfStartEv) begin
				fsdl_reg <= fsdlAsm_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	reg        rdPrev_reg;
	reg        rdStack_reg;
	reg  [7:0] rdMux;
	wire       cpuSel   = ~chip_select_n;
	wire       stackSel = (cpuSel & (addr == `OFS_SIG_STACK)) | ~dma_ack_n;
	wire       rdStart  = rdPrev_reg & ~rd_n;
	wire       rdEnd    = ~rdPrev_reg & rd_n;
	wire       anySel   = cpuSel | ~dma_ack_n;

	// register read mux; unmapped offsets read as zero
	always @* begin
		rdMux = 8'h00;
		if (stackSel) begin
			rdMux = stackByte;
		end else begin
			case (addr)
				`OFS_ALARM_SIM: rdMux = {simStep_reg, freezeSig_reg, `ALARM_SIM_FIXED,
					rxParErr_reg, txParErr_reg, txSlip_reg};
				`OFS_MF_STATUS: rdMux = {2'b00, dmaSlip_reg, globalPar_reg,
					rxRemoteSw_reg, rxMfBegin_reg, txRemoteSw_reg, txMfBegin_reg};
				`OFS_FRAMING:   rdMux = {mfLoss_reg, lineErr_reg, feh_reg};
				`OFS_FSDL:      rdMux = {`FSDL_PAD, fsdl_reg};
				`OFS_CNT_EXT:   rdMux = {4'h0, cntExtIn};
				default:        rdMux = 8'h00;
			endcase
		end
	end

	// data is captured at the strobe's fall and held for the whole strobe
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdPrev_reg   <= 1'b1;
			rdStack_reg  <= 1'b0;
			rdData_reg   <= 8'h00;
			rdDataOe_reg <= 1'b0;
		end else begin
			rdPrev_reg <= rd_n;
			if (rdStart && anySel) begin
				rdData_reg   <= rdMux;
				rdDataOe_reg <= 1'b1;
				rdStack_reg  <= stackSel;
			end else if (rd_n) begin
				rdDataOe_reg <= 1'b0;
				rdStack_reg  <= 1'b0;
			end
		end
	end

	// stack pointer moves at the end of each stack read; request drops after the third
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stackPtr_reg       <= 2'h0;
			rx_dma_request_reg <= 1'b0;
		end else begin
			if (stackReq) begin
				stackPtr_reg       <= 2'h0;
				rx_dma_request_reg <= 1'b1;
			end else if (rdEnd && rdStack_reg) begin
				if (stackPtr_reg == `STACK_DEPTH - 2'h1) begin
					stackPtr_reg       <= 2'h0;
					rx_dma_request_reg <= 1'b0;
				end else begin
					stackPtr_reg <= stackPtr_reg + 2'h1;
				end
			end
		end
	end

endmodule

// ==== testbench/t1_status_props.sv ====
// Purpose: port checks of the framer status block
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   the step is mirrored from simulate pulses
`timescale 1ns/1ps
module t1_status_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic chip_select_n,
	input wire logic rd_n,
	input wire logic dma_ack_n,
	input wire logic simulate_cmd,
	input wire logic rx_mf_ack,
	input wire logic rxMfStartEv,
	input wire logic rdDataOe_reg,
	input wire logic rx_mf_begin_out_reg,
	input wire logic simForceSlipPos_reg,
	input wire logic simForceSlipNeg_reg,
	input wire logic simForceLos_reg,
	input wire logic simForceFec_reg,
	input wire logic simForceNosClk_reg,
	input wire logic simAutoClear_reg
);
	logic [2:0] stepCnt;
	logic [1:0] cmdHist;
	logic       quiet;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// step mirror
	// ----------------------------------------
	// decodes are judged two idle edges after a command, so their latency stays free
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepCnt <= 3'h0;
			cmdHist <= 2'h0;
		end else begin
			if (simulate_cmd) stepCnt <= stepCnt + 3'h1;
			cmdHist <= {cmdHist[0], simulate_cmd};
		end
	end
	assign quiet = !simulate_cmd && (cmdHist == 2'h0);
	AST_SLIP_POS: assert property (quiet |-> simForceSlipPos_reg == (stepCnt == 3'h1))
		else $error("positive slip force wrong");
	AST_SLIP_NEG: assert property (quiet |-> simForceSlipNeg_reg == (stepCnt == 3'h5))
		else $error("negative slip force wrong");
	AST_LOS_FEC: assert property (quiet |->
		(simForceLos_reg && simForceFec_reg) == (stepCnt == 3'h2 || stepCnt == 3'h6))
		else $error("sync loss force wrong");
	AST_NOS_CLK: assert property (quiet |-> simForceNosClk_reg == (stepCnt == 3'h6))
		else $error("clock check force wrong");
	AST_AUTO_CLR: assert property (quiet |-> simAutoClear_reg ==
		(stepCnt == 3'h0 || stepCnt == 3'h3 || stepCnt == 3'h4 || stepCnt == 3'h7))
		else $error("auto clear wrong");
	AST_READ_TAKEN: assert property ($fell(rd_n) && !(chip_select_n && dma_ack_n)
		|=> rdDataOe_reg) else $error("read not answered");
	AST_OE_STROBE: assert property (rdDataOe_reg |-> !$past(rd_n))
		else $error("bus driven without strobe");
	AST_OE_DROP: assert property (rdDataOe_reg && rd_n |=> !rdDataOe_reg)
		else $error("bus not released");
	AST_BEGIN_SET: assert property (rxMfStartEv |=> rx_mf_begin_out_reg)
		else $error("begin pin not set");
	AST_BEGIN_ACK: assert property (rx_mf_ack && !rxMfStartEv |=> !rx_mf_begin_out_reg)
		else $error("begin pin not released");
endmodule
bind t1_framer_status_and_alarm_sim t1_status_props u_props (.sys_clk, .sys_rst,
	.chip_select_n, .rd_n, .dma_ack_n, .simulate_cmd, .rx_mf_ack, .rxMfStartEv,
	.rdDataOe_reg, .rx_mf_begin_out_reg, .simForceSlipPos_reg, .simForceSlipNeg_reg,
	.simForceLos_reg, .simForceFec_reg, .simForceNosClk_reg, .simAutoClear_reg);

// ==== testbench/host_bus_model.sv ====
// Purpose: host processor on the parallel read bus
// Assumes: strobes change on the falling clock edge
// Notes:   step spacing is scaled down; the block keeps no timer
`timescale 1ns/1ps
module host_bus_model #(
	parameter int STEP_GAP = 8
) (
	input  wire logic       sys_clk,
	input  wire logic [7:0] rdData_reg,
	input  wire logic       rdDataOe_reg,
	output logic            chip_select_n,
	output logic            rd_n,
	output logic            dma_ack_n,
	output logic [7:0]      addr,
	output logic            simulate_cmd,
	output logic            clear_cmd,
	output logic            rx_mf_ack
);
	initial begin
		{chip_select_n, rd_n, dma_ack_n} = 3'b111;
		{simulate_cmd, clear_cmd, rx_mf_ack} = 3'b000;
		addr = 8'h00;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// strobe held until the enable is seen; data taken at that same edge
	task automatic rd(input logic [7:0] a, input logic dma, output logic [7:0] d);
		int n;
		@(negedge sys_clk);
		addr = a;
		chip_select_n = dma;
		dma_ack_n = !dma;
		rd_n = 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rdDataOe_reg !== 1'b1 && n < 20);
		d = (rdDataOe_reg === 1'b1) ? rdData_reg : 8'hxx;
		@(negedge sys_clk);
		{chip_select_n, rd_n, dma_ack_n} = 3'b111;
		addr = ~a; // released lines do not keep their last value
		repeat (2) @(negedge sys_clk);
	endtask
	// command pulses: 0 simulate, 1 clear, 2 begin acknowledge
	task automatic cmd(input int w);
		@(negedge sys_clk);
		{simulate_cmd, clear_cmd, rx_mf_ack} = 3'b100 >> w;
		@(negedge sys_clk);
		{simulate_cmd, clear_cmd, rx_mf_ack} = 3'b000;
		repeat (STEP_GAP) @(negedge sys_clk);
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the framer status block
// Assumes: inputs change on the falling clock edge
// Notes:   event inputs pulse one cycle through a shared vector
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk, sys_rst, chip_select_n, rd_n, dma_ack_n, simulate_cmd;
	logic        clear_cmd, rx_mf_ack, losIn, rxFrame37, tx_mf_begin_out, txDChanStart;
	logic        mfFormat, mlosWindow5, mfPatBad, opticalEnable, rx_rail_pos_in;
	logic        rx_rail_neg_in, internal_sig_enable, sigMode, sig_channel_24_select;
	logic        sigBit, fsdlBit, rdDataOe_reg, rx_dma_request_reg, rx_mf_begin_out_reg;
	logic [4:0]  channel_select_reg, rxParityChan, txParityChan, sigChan;
	logic [2:0]  fbitPosIdx, fsdlIdx;
	logic [5:0]  dlSubstMask;
	logic [3:0]  cntExtIn;
	logic [7:0]  addr, rdData_reg;
	logic [13:0] ev;
	int          badCount, nChecks;
	localparam logic [23:0] SIG_PAT = 24'ha53c81;
	localparam logic [5:0]  FS_PAT  = 6'h2d;
	t1_framer_status_and_alarm_sim DUT (
		.sys_clk, .sys_rst, .chip_select_n, .rd_n, .dma_ack_n, .addr, .simulate_cmd,
		.clear_cmd, .channel_select_reg, .rxParityEv(ev[0]), .rxParityChan,
		.txParityEv(ev[1]), .txParityChan, .txSlipEv(ev[2]), .rxSlipEv(ev[3]),
		.fbitErrEv(ev[4]), .losIn, .mfGoodEv(ev[5]), .rxMfStartEv(ev[6]), .rxFrame37,
		.rx_mf_ack, .tx_mf_begin_out, .txDChanStart, .mfFormat, .mlosWindow5,
		.mfPatEv(ev[7]), .mfPatBad, .mfResyncEv(ev[8]), .opticalEnable, .rx_rail_pos_in,
		.rx_rail_neg_in, .fbitPosErrEv(ev[9]), .fbitPosIdx, .historyUpdateEv(ev[10]),
		.dlSubstMask, .internal_sig_enable, .sigMode, .sig_channel_24_select,
		.sigBitEv(ev[11]), .sigBit, .sigChan, .sigFrameEndEv(ev[12]), .fsdlBitEv(ev[13]),
		.fsdlBit, .fsdlIdx, .cntExtIn, .rdData_reg, .rdDataOe_reg, .rx_dma_request_reg,
		.rx_mf_begin_out_reg, .simForceSlipPos_reg(), .simForceSlipNeg_reg(),
		.simForceLos_reg(), .simForceFec_reg(), .simForceNosClk_reg(), .simAutoClear_reg());
	host_bus_model #(.STEP_GAP(8)) hb (.sys_clk, .rdData_reg, .rdDataOe_reg, .chip_select_n,
		.rd_n, .dma_ack_n, .addr, .simulate_cmd, .clear_cmd, .rx_mf_ack);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		nChecks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			badCount++;
		end
	endtask
	// masked register read, so bits owned by other tests cannot disturb this one
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
		input string nm);
		logic [7:0] d;
		hb.rd(a, 1'b0, d);
		chk(nm, e, d & m);
	endtask
	task automatic pl(input int b);
		@(negedge sys_clk);
		ev[b] = 1'b1;
		@(negedge sys_clk);
		ev[b] = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic s_flag;
		channel_select_reg = 5'h0c;
		rxParityChan = 5'h09;
		pl(0);
		rc(8'h04, 8'h04, 8'h00, "rxParOther");
		rc(8'h05, 8'h10, 8'h10, "globalPar");
		channel_select_reg = 5'h05;
		rxParityChan = 5'h05;
		txParityChan = 5'h05;
		pl(0);
		pl(1);
		pl(2);
		rc(8'h04, 8'h07, 8'h07, "parSlip");
		hb.cmd(1);
		rc(8'h04, 8'hff, 8'h08, "cleared");
		rc(8'h05, 8'h10, 8'h00, "globalParClr");
	endtask
	task automatic s_frz;
		pl(4);
		rc(8'h04, 8'h10, 8'h10, "frzFbit");
		pl(5);
		rc(8'h04, 8'h10, 8'h00, "frzGood");
		pl(3);
		rc(8'h04, 8'h10, 8'h10, "frzSlip");
		pl(5);
		losIn = 1'b1;
		pl(5);
		rc(8'h04, 8'h10, 8'h10, "frzLos");
		losIn = 1'b0;
		pl(5);
		rc(8'h04, 8'h10, 8'h00, "frzClr");
	endtask
	// all eight steps, ending back at step 0
	task automatic s_sim;
		logic [2:0] st;
		logic       rx, tx;
		for (int k = 1; k <= 8; k++) begin
			hb.cmd(0);
			st = 3'(k);
			rx = (st == 3'h5) || (st == 3'h6);
			tx = (st == 3'h1) || (st == 3'h2);
			rc(8'h04, 8'hef, {st, 2'b01, rx, tx, rx | tx}, "simStep");
			rc(8'h05, 8'h10, {3'h0, rx | tx, 4'h0}, "simGlobal");
		end
	endtask
	task automatic s_mf;
		mfFormat = 1'b1;
		pl(6);
		rc(8'h05, 8'h0c, 8'h04, "rxBegin");
		hb.cmd(2);
		rc(8'h05, 8'h0c, 8'h00, "rxBeginOff");
		rxFrame37 = 1'b1;
		pl(6);
		rc(8'h05, 8'h0c, 8'h08, "rxRemote");
		hb.cmd(2);
		tx_mf_begin_out = 1'b1;
		rc(8'h05, 8'h01, 8'h01, "txBegin");
		tx_mf_begin_out = 1'b0;
		rc(8'h05, 8'h01, 8'h00, "txBeginOff");
		txDChanStart = 1'b1;
		tx_mf_begin_out = 1'b1;
		rc(8'h05, 8'h02, 8'h02, "txRemote");
		tx_mf_begin_out = 1'b0;
		rc(8'h05, 8'h02, 8'h00, "txRemoteOff");
	endtask
	task automatic s_frm;
		mfPatBad = 1'b1;
		pl(7);
		mfPatBad = 1'b0;
		pl(7);
		pl(7);
		rc(8'h06, 8'h80, 8'h00, "mfLossOne");
		mfPatBad = 1'b1;
		pl(7);
		rc(8'h06, 8'h80, 8'h80, "mfLoss");
		pl(8);
		rc(8'h06, 8'h80, 8'h00, "mfLossClr");
		// two bad of five: a four-pattern window would see only one
		mlosWindow5 = 1'b1;
		for (int i = 0; i < 5; i++) begin
			mfPatBad = (i == 0 || i == 4);
			pl(7);
		end
		rc(8'h06, 8'h80, 8'h80, "mfLossWide");
		rx_rail_pos_in = 1'b1;
		rc(8'h06, 8'h40, 8'h00, "lineOne");
		rx_rail_neg_in = 1'b1;
		rc(8'h06, 8'h40, 8'h40, "lineBoth");
		opticalEnable = 1'b1;
		rc(8'h06, 8'h40, 8'h00, "lineOptical");
		dlSubstMask = 6'h01;
		pl(9);
		fbitPosIdx = 3'h5;
		pl(9);
		pl(10);
		rc(8'h06, 8'h3f, 8'h20, "fbitHistory");
	endtask
	// common-channel mode also feeds the other channel with the inverse bits
	task automatic ld(input logic mode);
		internal_sig_enable = 1'b1;
		sigMode = mode;
		for (int i = 0; i < 24; i++) begin
			sigBit = SIG_PAT[23 - i];
			sigChan = mode ? 5'(i + 1) : 5'h11;
			pl(11);
			if (!mode) begin
				sigChan = 5'h18;
				sigBit = !SIG_PAT[23 - i];
				pl(11);
			end
		end
		if (mode) pl(12);
	endtask
	task automatic s_stk(input logic mode);
		logic [7:0] d;
		int         n;
		ld(mode);
		n = 0;
		while (rx_dma_request_reg !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk("request", 8'h01, {7'h0, rx_dma_request_reg});
		repeat (4) @(negedge sys_clk);
		for (int j = 0; j < 3; j++) begin
			hb.rd(8'h07, j == 2, d);
			chk("stackByte", SIG_PAT[23 - 8 * j -: 8] ^ {8{sig_channel_24_select & ~mode}}, d);
		end
		chk("requestDrop", 8'h00, {7'h0, rx_dma_request_reg});
	endtask
	task automatic s_misc;
		ld(1'b1);
		ld(1'b1);
		rc(8'h05, 8'h20, 8'h20, "dmaSlip");
		hb.cmd(1);
		rc(8'h05, 8'h20, 8'h00, "dmaSlipClr");
		for (int i = 0; i < 6; i++) begin
			fsdlIdx = 3'(i);
			fsdlBit = FS_PAT[i];
			pl(13);
		end
		pl(6);
		rc(8'h80, 8'hff, 8'hed, "fsdl");
		cntExtIn = 4'h9;
		rc(8'h08, 8'hff, 8'h09, "cntExt");
		rc(8'h33, 8'hff, 8'h00, "unmapped");
	endtask
	task automatic results;
		if (badCount == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// run
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		sys_rst = 1'b1;
		ev = 14'h0;
		{losIn, rxFrame37, tx_mf_begin_out, txDChanStart, mfFormat, mlosWindow5} = 6'h00;
		{mfPatBad, opticalEnable, rx_rail_pos_in, rx_rail_neg_in, internal_sig_enable} = 5'h00;
		{sigMode, sig_channel_24_select, sigBit, fsdlBit} = 4'h0;
		{rxParityChan, txParityChan, sigChan, fbitPosIdx, fsdlIdx} = 21'h0;
		{dlSubstMask, cntExtIn} = 10'h000;
		channel_select_reg = 5'h05;
		badCount = 0;
		nChecks = 0;
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		s_flag();
		s_frz();
		s_sim();
		s_mf();
		s_frm();
		s_stk(1'b0);
		sig_channel_24_select = 1'b1;
		s_stk(1'b0);
		s_stk(1'b1);
		s_misc();
		results();
	end
	// hang guard, roughly twenty times the expected run length
	initial begin
		#100000;
		badCount++;
		results();
	end
endmodule
